/* verilog/ustx_pkg.sv */
// ustx_pkg: constants shared by the synchronous master transmitter files.
// assumes an 8-bit register port and a 20 MHz ref_clk.
// ============================================================
// register map and field layout
// ============================================================
package ustx_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 4;

    // register offsets
    localparam logic [2:0] ADDR_TX_STAT_CTRL = 3'h0;
    localparam logic [2:0] ADDR_RX_STAT_CTRL = 3'h1;
    localparam logic [2:0] ADDR_IRQ_FLAGS    = 3'h2;
    localparam logic [2:0] ADDR_IRQ_ENABLES  = 3'h3;
    localparam logic [2:0] ADDR_TX_HOLD      = 3'h4;
    localparam logic [2:0] ADDR_BAUD_DIV     = 3'h5;
    localparam logic [2:0] ADDR_RX_WORD      = 3'h6;

    // transmit status/control fields
    localparam int unsigned TSC_CLK_MASTER = 7;
    localparam int unsigned TSC_NINTH_EN   = 6;
    localparam int unsigned TSC_TX_EN      = 5;
    localparam int unsigned TSC_SYNC       = 4;
    localparam int unsigned TSC_SR_EMPTY   = 1;
    localparam int unsigned TSC_NINTH_VAL  = 0;
    // receive status/control fields
    localparam int unsigned RSC_PORT_EN    = 7;
    localparam int unsigned RSC_SINGLE_RX  = 5;
    localparam int unsigned RSC_CONT_RX    = 4;
    // interrupt flag/enable field
    localparam int unsigned IRQ_TX_BIT     = 4;

    // word lengths and reset values
    localparam logic [3:0] LEN_8BIT        = 4'h8;
    localparam logic [3:0] LEN_9BIT        = 4'h9;
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] RST_DIV         = 8'h00;

    typedef enum logic [1:0] {USTX_IDLE, USTX_SHIFT, USTX_PAUSED} ustx_state_t;
endpackage : ustx_pkg

/* verilog/ustx_baud_if.sv */
// ustx_baud_if: link between the transmitter and its baud generator.
// assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// baud generator link
// ============================================================
interface ustx_baud_if;
    logic [7:0] divisor;   // ticks every divisor+1 clocks
    logic       hold;      // generator kept in reset
    logic       tick;      // one-cycle shift clock phase pulse
    modport gen  (input divisor, input hold, output tick);
    modport user (output divisor, output hold, input tick);
endinterface : ustx_baud_if
`default_nettype wire

/* verilog/ustx_baud_gen.sv */
// ustx_baud_gen: divider giving one tick per half shift clock period.
// assumes divisor is stable while running; hold clears it at once.
`timescale 1ns/1ps
`default_nettype none
module ustx_baud_gen
    import ustx_pkg::*;
(
    // clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst,
    // link to transmitter
    ustx_baud_if.gen   bif
);
    logic [7:0] cnt_q;
    logic       tick_q;

    // ============================================================
    // divider, held in reset while the transmit, single receive and continuous receive enables are clear
    // ============================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end
        else if (bif.hold)
        begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end
        else if (cnt_q >= bif.divisor)
        begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    assign bif.tick = tick_q;

    // ============================================================
    // checks
    // ============================================================
    property p_hold_no_tick;
        @(posedge ref_clk) disable iff (rst)
        bif.hold |=> !bif.tick;
    endproperty
    a_hold_no_tick: assert property (p_hold_no_tick) else $error("tick while held");
endmodule : ustx_baud_gen
`default_nettype wire

/* verilog/ustx_top.sv */
// ustx_top: synchronous master serial transmitter with register port.
// assumes a one-cycle register master and an external slave on ck/dt.
// ============================================================
`timescale 1ns/1ps
`default_nettype none
module ustx_top
    import ustx_pkg::*;
(
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // register port
    input  wire logic [ustx_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ustx_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [ustx_pkg::DATA_W-1:0] reg_rdata,
    // serial pins
    output logic                             ck_o,
    output logic                             ck_oe,
    output logic                             dt_o,
    output logic                             dt_oe,
    input  wire logic                        dt_i,
    // interrupt request
    output logic                             tx_irq
);
    import ustx_pkg::*;

    // ============================================================
    // state
    // ============================================================
    logic        clk_master_q, ninth_en_q, tx_en_q, sync_q, ninth_val_q;
    logic        port_en_q, single_rx_q, cont_rx_q, irq_en_q;
    logic [7:0]  baud_div_q, tx_hold_q, rx_word_q, rdata_q;
    logic        hold_full_q;
    logic [8:0]  tsr_q;
    logic [3:0]  bits_left_q, rx_cnt_q;
    logic        ck_q, dt_q, ck_oe_q, dt_oe_q, irq_q;
    logic        dt_s1_q, dt_s2_q;
    ustx_state_t state_q;

    ustx_baud_if bif ();
    ustx_baud_gen u_baud (.ref_clk(ref_clk), .rst(rst), .bif(bif));

    // ============================================================
    // decode and combinational helpers
    // ============================================================
    logic       wr_tsc, wr_rsc, wr_hold, rx_on, sr_empty, load_now;
    logic       last_fall, tx_shift, rx_done;
    logic [3:0] word_len;

    assign wr_tsc   = reg_wr && (reg_addr == ADDR_TX_STAT_CTRL);
    assign wr_rsc   = reg_wr && (reg_addr == ADDR_RX_STAT_CTRL);
    assign wr_hold  = reg_wr && (reg_addr == ADDR_TX_HOLD);
    assign rx_on    = single_rx_q || cont_rx_q;
    assign sr_empty = (bits_left_q == 4'h0);
    assign word_len = ninth_en_q ? LEN_9BIT : LEN_8BIT;
    assign tx_shift = tx_en_q && !rx_on && !sr_empty;
    // final falling edge of a word frees the shift register this cycle
    assign last_fall = tx_shift && bif.tick && ck_q && (bits_left_q == 4'h1);
    // move only when the previous word is fully out
    assign load_now = tx_en_q && hold_full_q && (sr_empty || last_fall);
    assign rx_done  = rx_on && bif.tick && ck_q && (rx_cnt_q == word_len - 4'h1);
    assign bif.hold    = !(tx_en_q || cont_rx_q || single_rx_q);
    assign bif.divisor = baud_div_q;

    // ============================================================
    // control registers
    // ============================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_master_q <= 1'b0;
            ninth_en_q   <= 1'b0;
            tx_en_q      <= 1'b0;
            sync_q       <= 1'b0;
            ninth_val_q  <= 1'b0;
            port_en_q    <= 1'b0;
            cont_rx_q    <= 1'b0;
            irq_en_q     <= 1'b0;
            baud_div_q   <= RST_DIV;
        end
        else
        begin
            if (wr_tsc)
            begin
                clk_master_q <= reg_wdata[TSC_CLK_MASTER];
                ninth_en_q   <= reg_wdata[TSC_NINTH_EN];
                tx_en_q      <= reg_wdata[TSC_TX_EN];
                sync_q       <= reg_wdata[TSC_SYNC];
                ninth_val_q  <= reg_wdata[TSC_NINTH_VAL];
            end
            if (wr_rsc)
            begin
                port_en_q <= reg_wdata[RSC_PORT_EN];
                cont_rx_q <= reg_wdata[RSC_CONT_RX];
            end
            if (reg_wr && (reg_addr == ADDR_IRQ_ENABLES))
                irq_en_q <= reg_wdata[IRQ_TX_BIT];
            if (reg_wr && (reg_addr == ADDR_BAUD_DIV))
                baud_div_q <= reg_wdata;
        end
    end

    // single receive: hardware clear after one word beats a software write
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            single_rx_q <= 1'b0;
        else if (single_rx_q && rx_done)
            single_rx_q <= 1'b0;
        else if (wr_rsc)
            single_rx_q <= reg_wdata[RSC_SINGLE_RX];
    end

    // ============================================================
    // holding buffer; empty flag is simply its inverse
    // ============================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_hold_q   <= RST_BYTE;
            hold_full_q <= 1'b0;
        end
        else
        begin
            if (wr_hold)
            begin
                tx_hold_q   <= reg_wdata;
                hold_full_q <= 1'b1;
            end
            else if (load_now)
                hold_full_q <= 1'b0;
        end
    end

    // ============================================================
    // transmitter state and shift register
    // ============================================================
    // a write in the move cycle is kept: the old byte leaves, the new one stays
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tsr_q       <= 9'h000;
            bits_left_q <= 4'h0;
            state_q     <= USTX_IDLE;
        end
        else if (!tx_en_q)
        begin
            tsr_q       <= 9'h000;
            bits_left_q <= 4'h0;
            state_q     <= USTX_IDLE;
        end
        else if (load_now)
        begin
            tsr_q       <= {ninth_val_q, tx_hold_q};
            bits_left_q <= word_len;
            state_q     <= rx_on ? USTX_PAUSED : USTX_SHIFT;
        end
        else
        begin
            case (state_q)
                USTX_IDLE:
                    state_q <= USTX_IDLE;
                USTX_SHIFT:
                begin
                    if (rx_on)
                        state_q <= USTX_PAUSED;
                    else if (bif.tick && ck_q)
                    begin
                        tsr_q       <= {1'b0, tsr_q[8:1]};
                        bits_left_q <= bits_left_q - 4'h1;
                        if (bits_left_q == 4'h1)
                            state_q <= USTX_IDLE;
                    end
                end
                USTX_PAUSED:
                    if (!rx_on)
                        state_q <= sr_empty ? USTX_IDLE : USTX_SHIFT;
                default:
                    state_q <= USTX_IDLE;
            endcase
        end
    end

    // ============================================================
    // shift clock and data line
    // ============================================================
    // clock idles low; data changes on the rising edge only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ck_q <= 1'b0;
            dt_q <= 1'b0;
        end
        else if (!tx_en_q && !rx_on)
        begin
            ck_q <= 1'b0;
            dt_q <= 1'b0;
        end
        // a move alone must not raise the clock; its first bit waits for the next rise
        else if (bif.tick && (tx_shift || rx_on))
        begin
            ck_q <= !ck_q;
            if (!ck_q && tx_shift)
                dt_q <= tsr_q[0];
        end
    end

    // pin ownership, one cycle behind the control bits
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ck_oe_q <= 1'b0;
            dt_oe_q <= 1'b0;
        end
        else
        begin
            ck_oe_q <= port_en_q && sync_q && clk_master_q && (tx_en_q || rx_on);
            dt_oe_q <= port_en_q && sync_q && tx_en_q && !rx_on;
        end
    end

    // ============================================================
    // minimal receive path, needed for the single-word interruption
    // ============================================================
    // data pin is synchronised; sample on falling clock edges
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dt_s1_q   <= 1'b0;
            dt_s2_q   <= 1'b0;
            rx_cnt_q  <= 4'h0;
            rx_word_q <= RST_BYTE;
        end
        else
        begin
            dt_s1_q <= dt_i;
            dt_s2_q <= dt_s1_q;
            if (!rx_on)
                rx_cnt_q <= 4'h0;
            else if (bif.tick && ck_q)
            begin
                rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
                if (rx_cnt_q < LEN_8BIT)
                    rx_word_q <= {dt_s2_q, rx_word_q[7:1]};
            end
        end
    end

    // ============================================================
    // read port and interrupt request
    // ============================================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= RST_BYTE;
            irq_q   <= 1'b0;
        end
        else
        begin
            irq_q   <= !hold_full_q && irq_en_q;
            rdata_q <= RST_BYTE;
            if (reg_rd)
                case (reg_addr)
                    ADDR_TX_STAT_CTRL: rdata_q <= {clk_master_q, ninth_en_q, tx_en_q, sync_q,
                                                   2'b00, sr_empty, ninth_val_q};
                    ADDR_RX_STAT_CTRL: rdata_q <= {port_en_q, 1'b0, single_rx_q, cont_rx_q, 4'h0};
                    ADDR_IRQ_FLAGS:    rdata_q <= {3'b000, !hold_full_q, 4'h0};
                    ADDR_IRQ_ENABLES:  rdata_q <= {3'b000, irq_en_q, 4'h0};
                    ADDR_TX_HOLD:      rdata_q <= tx_hold_q;
                    ADDR_BAUD_DIV:     rdata_q <= baud_div_q;
                    ADDR_RX_WORD:      rdata_q <= rx_word_q;
                    default:           rdata_q <= RST_BYTE;
                endcase
        end
    end

    assign reg_rdata = rdata_q;
    assign ck_o      = ck_q;
    assign ck_oe     = ck_oe_q;
    assign dt_o      = dt_q;
    assign dt_oe     = dt_oe_q;
    assign tx_irq    = irq_q;

    // ============================================================
    // checks
    // ============================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_move_sets_flag;
        load_now && !wr_hold |=> !hold_full_q && !sr_empty;
    endproperty
    a_move_sets_flag: assert property (p_move_sets_flag) else $error("move did not empty buffer");

    property p_write_clears_flag;
        wr_hold |=> hold_full_q ##1 (hold_full_q || $past(load_now));
    endproperty
    a_write_clears_flag: assert property (p_write_clears_flag) else $error("flag stayed set");

    property p_irq_gate;
        !irq_en_q |=> !tx_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

    property p_shift_reg_empty_read;
        reg_rd && (reg_addr == ADDR_TX_STAT_CTRL) |=> reg_rdata[TSC_SR_EMPTY] == $past(sr_empty);
    endproperty
    a_shift_reg_empty_read: assert property (p_shift_reg_empty_read) else $error("empty bit wrong");

    property p_rise_drives_bit;
        tx_shift && bif.tick && !ck_q && !load_now |=> ck_q && (dt_q == $past(tsr_q[0]));
    endproperty
    a_rise_drives_bit: assert property (p_rise_drives_bit) else $error("bit not on rise");

    property p_disable_aborts;
        $fell(tx_en_q) |=> sr_empty && !dt_oe ##1 !dt_oe;
    endproperty
    a_disable_aborts: assert property (p_disable_aborts) else $error("abort incomplete");

    property p_rx_floats_dt;
        rx_on |=> !dt_oe;
    endproperty
    a_rx_floats_dt: assert property (p_rx_floats_dt) else $error("data driven in rx");

    property p_single_clears;
        single_rx_q && rx_done |=> !single_rx_q;
    endproperty
    a_single_clears: assert property (p_single_clears) else $error("single rx stuck");

    property p_ck_owner;
        ck_oe |-> $past(clk_master_q && sync_q && port_en_q);
    endproperty
    a_ck_owner: assert property (p_ck_owner) else $error("clock driven without master");

    property p_no_send_empty;
        sr_empty && !load_now && !rx_on && tx_en_q |=> $stable(ck_q);
    endproperty
    a_no_send_empty: assert property (p_no_send_empty) else $error("clock with no data");

    c_back_to_back: cover property (last_fall && load_now);
    c_single_rx:    cover property (single_rx_q && rx_done && tx_en_q);
    c_abort:        cover property ($fell(tx_en_q) && !sr_empty);
    c_ninth:        cover property (load_now && ninth_en_q);
endmodule : ustx_top
`default_nettype wire

/* verification/ustx_slave.sv */
// ustx_slave: synchronous slave on the far side of the ck/dt pins.
// assumes ck and the enables come straight from the design's pin outputs.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// slave receiver and single word responder
// ============================================================
module ustx_slave
(
    // pins from the master
    input  wire logic       ck,
    input  wire logic       ck_en,
    input  wire logic       dt_o,
    input  wire logic       dt_oe,
    // word returned while the master listens
    input  wire logic [7:0] rx_byte,
    // resolved data line level
    output logic            dt_i
);
    bit         got_q[$];
    logic [3:0] nfall_q;
    logic [3:0] bit_idx_q;
    logic       last_q;

    // capture on the falling clock edge, where master data is stable
    always @(negedge ck)
    begin
        if (ck_en && dt_oe)
            got_q.push_back(dt_i);
    end
    // count falls while we own the line
    always @(negedge ck or posedge dt_oe)
    begin
        if (dt_oe)
            nfall_q <= 4'h0;
        else if (ck_en)
            nfall_q <= nfall_q + 4'h1;
    end
    // advance only after a rise, so each bit holds across the next fall
    always @(posedge ck or posedge dt_oe)
    begin
        if (dt_oe)
            bit_idx_q <= 4'h0;
        else
            bit_idx_q <= nfall_q;
    end
    // released line has no pull, so show the inverse of its last level
    always @(negedge dt_oe)
    begin
        last_q = dt_o;
    end
    assign dt_i = dt_oe ? dt_o : (ck_en ? rx_byte[bit_idx_q[2:0]] : ~last_q);
endmodule // ustx_slave
`default_nettype wire

/* verification/tb.sv */
// tb: self-checking bench for the synchronous master transmitter.
// assumes ustx_pkg and the slave model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ustx_pkg::*;
    logic       ref_clk;
    logic       rst;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       ck_o;
    logic       ck_oe;
    logic       dt_o;
    logic       dt_oe;
    logic       dt_i;
    logic       tx_irq;
    logic [7:0] rx_byte;
    int         error_cnt;
    int         comparisons;
    int         cycles;
    bit         exp_q[$];

    ustx_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ck_o(ck_o), .ck_oe(ck_oe),
        .dt_o(dt_o), .dt_oe(dt_oe), .dt_i(dt_i), .tx_irq(tx_irq));
    ustx_slave u_slave (.ck(ck_o), .ck_en(ck_oe), .dt_o(dt_o), .dt_oe(dt_oe), .rx_byte(rx_byte),
        .dt_i(dt_i));

    // ============================================================
    // clock, timeout and closing
    // ============================================================
    always #25 ref_clk = ~ref_clk;
    // whole run needs several hundred cycles; anything far beyond is a hang
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ============================================================
    // checks and register port
    // ============================================================
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // model: low bit first, ninth bit last when enabled
    task automatic send(input logic [7:0] b, input bit ninth, input bit nine);
        for (int i = 0; i < 8; i++)
            exp_q.push_back(b[i]);
        if (nine)
            exp_q.push_back(ninth);
        wr(ADDR_TX_HOLD, b);
    endtask
    task automatic drain();
        for (int i = 0; i < 3000 && u_slave.got_q.size() < exp_q.size(); i++)
            @(posedge ref_clk);
        chk("bit count", 9'(u_slave.got_q.size()), 9'(exp_q.size()));
        while (exp_q.size() > 0)
            chk("serial bit", 9'(u_slave.got_q.pop_front()), 9'(exp_q.pop_front()));
    endtask

    // ============================================================
    // main sequence
    // ============================================================
    initial
    begin
        logic [7:0] d;
        logic [7:0] tsc;
        ref_clk = 1'b0;
        rst = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rx_byte = 8'h00;
        void'($urandom(24));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // reset state and register protection
        rd(ADDR_TX_STAT_CTRL, d);
        chk("tsc reset", 9'(d), 9'h002);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        rd(ADDR_IRQ_FLAGS, d);
        chk("flag after sw write", 9'(d), 9'h010);
        rd(3'h7, d);
        chk("unmapped", 9'(d), 9'h000);
        chk("ck_oe idle", 9'(ck_oe), 9'h000);
        // setup in the documented order, transmit enabled before any data
        wr(ADDR_BAUD_DIV, 8'h03);
        tsc = (8'h01 << TSC_CLK_MASTER) | (8'h01 << TSC_SYNC);
        wr(ADDR_TX_STAT_CTRL, tsc);
        wr(ADDR_RX_STAT_CTRL, 8'h01 << RSC_PORT_EN);
        wr(ADDR_IRQ_ENABLES, 8'h01 << IRQ_TX_BIT);
        tsc = tsc | (8'h01 << TSC_TX_EN);
        wr(ADDR_TX_STAT_CTRL, tsc);
        repeat (40) @(posedge ref_clk);
        chk("bits before load", 9'(u_slave.got_q.size()), 9'h000);
        // two words back to back
        send(8'($urandom), 1'b0, 1'b0);
        repeat (3) @(posedge ref_clk);
        chk("irq after move", 9'(tx_irq), 9'h001);
        send(8'($urandom), 1'b0, 1'b0);
        rd(ADDR_IRQ_FLAGS, d);
        chk("flag while full", 9'(d), 9'h000);
        rd(ADDR_TX_STAT_CTRL, d);
        chk("shift busy", 9'(d), 9'(tsc));
        drain();
        rd(ADDR_TX_STAT_CTRL, d);
        chk("shift empty", 9'(d), 9'(tsc | 8'h02));
        wr(ADDR_IRQ_ENABLES, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk("irq masked", 9'(tx_irq), 9'h000);
        // nine-bit words, ninth value written before the data
        for (int k = 0; k < 2; k++)
        begin
            d = tsc | (8'h01 << TSC_NINTH_EN) | 8'(k == 0);
            wr(ADDR_TX_STAT_CTRL, d);
            send(8'($urandom), k == 0, 1'b1);
            drain();
        end
        wr(ADDR_TX_STAT_CTRL, tsc);
        // abort by clearing transmit enable mid-word
        send(8'($urandom), 1'b0, 1'b0);
        repeat (20) @(posedge ref_clk);
        wr(ADDR_TX_STAT_CTRL, tsc & ~(8'h01 << TSC_TX_EN));
        repeat (2) @(posedge ref_clk);
        chk("abort ck_oe", 9'({ck_oe, dt_oe, ck_o}), 9'h000);
        rd(ADDR_TX_STAT_CTRL, d);
        chk("abort empty", 9'(d[TSC_SR_EMPTY]), 9'h001);
        exp_q.delete();
        u_slave.got_q.delete();
        // single receive interrupts a word, then transmit resumes
        wr(ADDR_TX_STAT_CTRL, tsc);
        send(8'($urandom), 1'b0, 1'b0);
        rx_byte <= 8'($urandom);
        repeat (20) @(posedge ref_clk);
        // start receive just after a fall, so no bit is cut in half
        @(negedge ck_o);
        wr(ADDR_RX_STAT_CTRL, (8'h01 << RSC_PORT_EN) | (8'h01 << RSC_SINGLE_RX));
        repeat (2) @(posedge ref_clk);
        chk("rx pins", 9'({ck_oe, dt_oe}), 9'h002);
        for (int i = 0; i < 400 && !dt_oe; i++)
            @(posedge ref_clk);
        chk("resume drive", 9'(dt_oe), 9'h001);
        rd(ADDR_RX_STAT_CTRL, d);
        chk("single cleared", 9'(d), 9'h080);
        rd(ADDR_RX_WORD, d);
        chk("rx word", 9'(d), 9'(rx_byte));
        drain();
        stop_test();
    end
endmodule // tb
`default_nettype wire
